// ---- test/dev_phy_model.sv ----
// Purpose: far phy sending wake bursts
// Assumes: burst shows as a level
// Notes: offset keeps it off the edge
`timescale 1ns/1ns
module dev_phy_model (
  input wire logic i_clk,
  input wire logic i_go,
  output logic o_wake
);
  initial o_wake = 1'h0;
  always @(posedge i_clk) begin
    if (i_go) begin
      #3 o_wake = 1'h1;
      #40 o_wake = 1'h0;
    end
  end
endmodule : dev_phy_model

// ---- test/host_phy_slumber_wake_speed_tb_top.sv ----
// Purpose: bench for slumber exit and rate change
// Assumes: 100 MHz clock
// Notes: machine reset pulsed once at the end
`timescale 1ns/1ns
module host_phy_slumber_wake_speed_tb_top;
  import slumber_speed_pkg::*;
  logic clk = 0, rst_n = 0, req = 0, rec = 0, rdn = 0, rdy = 0, spd = 0, go = 0, mrs = 0;
  logic wk, owed, woke;
  phy_state_t st;
  tx_ctrl_t tx;
  int n_errors = 0, comparisons = 0, n;
  host_phy_slumber_wake_speed u_host_phy_slumber_wake_speed (.i_clk(clk), .i_rst_n(rst_n),
    .i_slumber_req(req), .i_dev_wake_det(wk), .i_recovered(rec), .i_rate_done(rdn),
    .i_enter_ready(rdy), .i_enter_speed(spd), .i_machine_reset(mrs), .o_state(st),
    .o_tx(tx), .o_wake_owed(owed), .o_dev_woke(woke));
  dev_phy_model u_dev_phy_model (.i_clk(clk), .i_go(go), .o_wake(wk));
  initial forever #5 clk = ~clk;
  initial begin
    #5000;
    n_errors++;
    end_of_test;
  end
  task step(int k);
    repeat (k) @(posedge clk);
  endtask : step
  task chk(logic [7:0] g, e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask : chk
  task wait_st(phy_state_t e);
    for (int i = 0; i < 20 && st !== e; i++) step(1);
    chk(st, e);
  endtask : wait_st
  initial begin
    void'($urandom(32'h3434dcfc));
    step(8);
    rst_n <= 1;
    for (int w = 0; w < 2; w++) begin
      rdy <= 1;
      step(1);
      rdy <= 0;
      req <= 1;
      rec <= 1;
      wait_st(host_low_power_deep_state);
      go <= w[0];
      step(1);
      go <= 0;
      step(6 + $urandom % 4);
      rec <= 0;
      step(3);
      req <= 0;
      step(6);
      chk(st, host_low_power_deep_state);
      rec <= 1;
      wait_st(w ? host_wait_wake_end_state : host_send_wake_burst_state);
      chk(woke, 8'(w));
      chk(8'(tx), w ? 8'h00 : 8'h02);
    end
    rdy <= 1;
    step(1);
    rdy <= 0;
    step(3);
    chk({owed, woke}, 8'h00);
    spd <= 1;
    step(1);
    spd <= 0;
    n = 0;
    repeat (12) begin
      step(1);
      n += tx.invalid_ok;
    end
    chk(8'(n), 8'h05);
    chk(st, host_rate_change_state);
    rdn <= 1;
    wait_st(host_transmit_align_prims_state);
    chk(8'(tx), 8'h01);
    mrs <= 1;
    step(1);
    mrs <= 0;
    step(1);
    chk(st, host_other_state);
    end_of_test;
  end
  task end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
endmodule : host_phy_slumber_wake_speed_tb_top

// ---- test/hp_chk.sv ----
// Purpose: port checker
// Assumes: one clock
// Notes: sync inputs lag two edges
`timescale 1ns/1ns
module hp_chk import slumber_speed_pkg::*; (
  input wire logic i_clk, i_rst_n, i_slumber_req, i_dev_wake_det, i_recovered, i_rate_done,
  input wire logic i_enter_ready, i_enter_speed, i_machine_reset, o_wake_owed, o_dev_woke,
  input wire phy_state_t o_state,
  input wire tx_ctrl_t o_tx
);
  wire sl = o_state == host_low_power_deep_state;
  wire rc = o_state == host_rate_change_state;
  // enter pulses outrank own moves, so mask them
  wire ok = !(i_machine_reset | i_enter_speed | i_enter_ready);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  slp_hold_a: assert property (sl && i_slumber_req && ok |=> sl)
    else $error("hold");
  wake_exit_a: assert property (sl && ok ##1 !sl |->
    !$past(i_slumber_req) && $past(i_recovered, 3)) else $error("exit");
  burst_pick_a: assert property (sl ##1 o_state == host_send_wake_burst_state |->
    !o_dev_woke) else $error("pick");
  rate_exit_a: assert property (rc && i_rate_done |-> ##[1:4] !rc)
    else $error("rate");
  rate_stay_a: assert property (!i_rate_done [*4] ##0 (rc && ok) |=> rc)
    else $error("stay");
  tx_live_a: assert property (rc |-> !o_tx.quiet) else $error("quiet");
  invalid_span_a: assert property ($rose(o_tx.invalid_ok) |->
    o_tx.invalid_ok [*5] ##1 !o_tx.invalid_ok) else $error("span");
  slp_quiet_a: assert property (sl |-> o_tx.quiet && o_wake_owed)
    else $error("owed");
  cover property (sl ##1 !sl);
  cover property (rc ##1 !rc);
  cover property (o_dev_woke);
endmodule : hp_chk
bind host_phy_slumber_wake_speed hp_chk u_hp_chk (.*);

// ---- verilog/host_phy_slumber_wake_speed.sv ----
// Purpose: host phy slumber exit and speed adjust portion of init machine
// Assumes: recovery, rate-done and wake-detect arrive asynchronously from analog
// Notes: rest of the init machine enters via i_enter_* pulses
// Functional notes
// - In slumber, a dropped slumber request with no device wake goes to wake-burst-send.
// - In slumber, a dropped slumber request with a device wake goes to wait-wake-end.
// - Slumber is held while the link layer keeps its slumber request asserted, unless an i_enter_* pulse or i_machine_reset overrides it.
// - A device wake seen during slumber is recorded to tell who asked for wakeup.
// - No slumber exit to wake-burst-send or wait-wake-end is taken until the phy has recovered.
// - Speed adjust moves to align-send once the rate change completes, else stays.
// - The transmitter is never quiescent during speed adjust.
// - Invalid signalling in speed adjust is limited to the 53 ns window.
// - Entering slumber sets the wake-owed flag and holds the line quiescent.
// - From link-up ready, an asserted slumber request enters slumber.
`timescale 1ns/1ns
`include "slumber_speed_params.svh"
module host_phy_slumber_wake_speed (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_slumber_req,
  input wire logic i_dev_wake_det,
  input wire logic i_recovered,
  input wire logic i_rate_done,
  input wire logic i_enter_ready,
  input wire logic i_enter_speed,
  input wire logic i_machine_reset,
  output slumber_speed_pkg::phy_state_t o_state,
  output slumber_speed_pkg::tx_ctrl_t o_tx,
  output logic o_wake_owed,
  output logic o_dev_woke
);
  import slumber_speed_pkg::*;

  // two-flop synchronisers for analog-side levels
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {i_dev_wake_det, i_recovered, i_rate_done};
      sync2_q <= sync1_q;
    end
  end
  logic wake_s;
  logic recov_s;
  logic rate_s;
  assign wake_s = sync2_q[2];
  assign recov_s = sync2_q[1];
  assign rate_s = sync2_q[0];

  phy_state_t state_q;
  phy_state_t state_d;
  logic dev_woke_q;
  logic [`INVALID_CNT_W-1:0] inval_cnt_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      host_link_up_state: begin
        if (i_slumber_req) begin
          state_d = host_low_power_deep_state;
        end
      end
      host_low_power_deep_state: begin
        // exits need recovery; request wins while held
        if (!i_slumber_req && recov_s) begin
          if (dev_woke_q || wake_s) begin
            state_d = host_wait_wake_end_state;
          end else begin
            state_d = host_send_wake_burst_state;
          end
        end
      end
      host_rate_change_state: begin
        if (rate_s) begin
          state_d = host_transmit_align_prims_state;
        end
      end
      default: begin
        state_d = state_q;
      end
    endcase
    if (i_enter_ready) begin
      state_d = host_link_up_state;
    end
    if (i_enter_speed) begin
      state_d = host_rate_change_state;
    end
    if (i_machine_reset) begin
      state_d = host_other_state;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= host_other_state;
    end else begin
      state_q <= state_d;
    end
  end

  // sticky device-wake record during slumber
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dev_woke_q <= 1'b0;
    end else if (state_q == host_low_power_deep_state && wake_s) begin
      dev_woke_q <= 1'b1;
    end else if (i_machine_reset || state_q == host_link_up_state) begin
      dev_woke_q <= 1'b0;
    end
  end

  // wake-owed flag; cleared on return to ready or on machine reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wake_owed <= 1'b0;
    end else if (state_d == host_low_power_deep_state) begin
      o_wake_owed <= 1'b1;
    end else if (state_d == host_link_up_state || i_machine_reset) begin
      o_wake_owed <= 1'b0;
    end
  end

  // invalid window counts from speed-adjust entry, then stays closed
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      inval_cnt_q <= '0;
    end else if (state_d == host_rate_change_state && state_q != host_rate_change_state) begin
      inval_cnt_q <= `INVALID_CNT_W'(`INVALID_SIG_CYCLES);
    end else if (inval_cnt_q != '0) begin
      inval_cnt_q <= inval_cnt_q - `INVALID_CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_state <= host_other_state;
      o_tx <= '0;
      o_dev_woke <= 1'b0;
    end else begin
      o_state <= state_d;
      o_dev_woke <= dev_woke_q;
      o_tx.quiet <= (state_d == host_low_power_deep_state);
      o_tx.wake_burst <= (state_d == host_send_wake_burst_state);
      o_tx.align <= (state_d == host_transmit_align_prims_state);
      // window only opens on entry; a held state cannot reopen it
      o_tx.invalid_ok <= (state_d == host_rate_change_state) &&
                         ((state_q != host_rate_change_state) ||
                          (inval_cnt_q > `INVALID_CNT_W'(1)));
    end
  end
endmodule : host_phy_slumber_wake_speed

// ---- verilog/slumber_speed_params.svh ----
// Purpose: timing constants for the slumber exit and rate change logic
// Assumes: 100 MHz clock
// Notes: invalid signalling window rounds down to whole cycles
`ifndef SLUMBER_SPEED_PARAMS_SVH
`define SLUMBER_SPEED_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define INVALID_SIG_MAX_NS 53
`define INVALID_SIG_CYCLES (`INVALID_SIG_MAX_NS / `CLK_PERIOD_NS)
`define INVALID_CNT_W 4
`endif

// ---- verilog/slumber_speed_pkg.sv ----
// Purpose: types for the slumber exit and rate change logic
// Assumes: one clock domain
// Notes: none
package slumber_speed_pkg;
  typedef enum logic [2:0] {
    host_link_up_state,
    host_low_power_deep_state,
    host_send_wake_burst_state,
    host_wait_wake_end_state,
    host_rate_change_state,
    host_transmit_align_prims_state,
    host_other_state
  } phy_state_t;

  typedef struct packed {
    logic quiet;
    logic invalid_ok;
    logic wake_burst;
    logic align;
  } tx_ctrl_t;
endpackage : slumber_speed_pkg
